/* src/pom_defines.svh */
// Constants of the serial-bus on/off, margin and write-lock command logic.
// Assumes the includer has no other macros with the POM_ prefix.
//
// Contract
// - On bit 0 stops switching, drivers low.
// - Decode the four margin field codes.
// - Margin low/high selects stored target value.
// - Fault thresholds follow reference now in effect.
// - Power-up bit 0 starts whenever powered.
// - Bus-command bit gates the on bit.
// - Enable-response bit gates the enable pin.
// - Polarity changes only after store and power cycle.
// - Off-action bit reads 1; off fast.
// - Configuration and lock savable to non-volatile store.
// - Clear-faults clears all status, releases alert.
// - Clear-faults never restarts a latched-off converter.
// - Persisting fault sets status and alert again.
// - Every command stays readable under any lock.
// - Lock bit 5 allows lock, operation, config.
// - Lock bit 6 allows lock and operation.
// - Lock bit 7 allows only lock writes.
// - Several lock bits set raises communication fault.
// - Config field access and printed defaults kept.
`ifndef POM_DEFINES_SVH
`define POM_DEFINES_SVH

// Command codes
`define POM_CMD_OPERATION   8'h01
`define POM_CMD_ONOFF       8'h02
`define POM_CMD_CLEAR       8'h03
`define POM_CMD_WLOCK       8'h10
`define POM_CMD_STORE_ALL   8'h11
`define POM_CMD_STORE_CODE  8'h13
`define POM_CMD_MARGIN_HIGH 8'h25
`define POM_CMD_MARGIN_LOW  8'h26
`define POM_CMD_STATUS_BYTE 8'h78
`define POM_CMD_STATUS_WORD 8'h79

// Field positions
`define POM_OP_ON      7
`define POM_OP_MG_MSB  5
`define POM_OP_MG_LSB  2
`define POM_WL_B7      7
`define POM_WL_B6      6
`define POM_WL_B5      5
`define POM_ST_OV      5
`define POM_ST_OC      4
`define POM_ST_OT      2
`define POM_ST_CML     1
`define POM_ST_UV      0

// Margin codes
`define POM_MG_LOW_IGN  4'h5
`define POM_MG_LOW_ACT  4'h6
`define POM_MG_HIGH_IGN 4'h9
`define POM_MG_HIGH_ACT 4'hA

// Reset values
`define POM_OP_RST      8'h00
`define POM_ONOFF_RST   4'hB
`define POM_CPA_VALUE   1'b1
`define POM_WL_RST      3'h0
`define POM_MARGIN_RST  16'h0000
`define POM_VOUT_NOM    16'h0000
`define POM_SLAVE_ADDR  7'h2C

`endif

/* src/pom_pkg.sv */
// Types of the serial-bus on/off, margin and write-lock command logic.
// Assumes nothing beyond a SystemVerilog compiler.
package pom_pkg;
	// Serial engine states, one-hot
	typedef enum logic [4:0] {
		POM_IDLE = 5'b00001,
		POM_RX   = 5'b00010,
		POM_ACK  = 5'b00100,
		POM_TX   = 5'b01000,
		POM_TACK = 5'b10000
	} pom_state_t;
	// Margin selection in effect
	typedef enum logic [1:0] {
		POM_MG_OFF  = 2'h0,
		POM_MG_LOW  = 2'h1,
		POM_MG_HIGH = 2'h2
	} pom_margin_t;
	// Fault comparator levels
	typedef struct packed {
		logic ov;
		logic uv;
		logic oc;
		logic ot;
	} pom_fault_t;
	// Power stage control
	typedef struct packed {
		logic switch_en;
		logic gates_low;
	} pom_drive_t;
endpackage

/* src/pom_top.sv */
// Serial-bus slave holding operation, turn-on configuration and write lock,
// with fault status, alert release and the switching enable.
// Assumes the bus clock, data and enable pin are asynchronous and are
// resynchronised here; fault levels come from logic on i_clk.
`timescale 1ns/1ps
`include "pom_defines.svh"
module pom_top #(
	parameter logic [6:0] SLAVE_ADDR = `POM_SLAVE_ADDR
) (
	// Clock and resets
	input  wire logic            i_clk,
	input  wire logic            i_rst,
	input  wire logic            i_nvm_clr,
	// Serial link
	input  wire logic            i_scl,
	input  wire logic            i_sda,
	output logic                 o_sda_o,
	output logic                 o_sda_oe,
	// Alert line, open drain
	output logic                 o_alert_o,
	output logic                 o_alert_oe,
	// Unit interface
	input  wire logic            i_enable_pin,
	input  pom_pkg::pom_fault_t  i_fault,
	output pom_pkg::pom_drive_t  o_drive,
	output logic [15:0]          o_ref_target,
	output pom_pkg::pom_margin_t o_margin,
	output logic [7:0]           o_status
);
	import pom_pkg::*;

	// Reserved general-call address cannot be served
	if (SLAVE_ADDR == 7'h00) begin : g_chk
		$error("SLAVE_ADDR must not be zero");
	end

	logic [1:0]  scl_sy, sda_sy, en_sy;   // Two-stage synchronisers
	logic        scl_p, sda_p;            // Previous synchronised levels
	pom_state_t  state_reg;               // Serial engine state
	logic [2:0]  bit_reg;                 // Bit within byte
	logic [7:0]  rx_reg, tx_reg;          // Shift registers
	logic        ack_on_reg;              // Acknowledge bit being driven
	logic [1:0]  bidx_reg;                // Byte index, saturating
	logic [1:0]  wcnt_reg;                // Data bytes written, saturating
	logic [1:0]  rcnt_reg;                // Bytes read, saturating
	logic        rw_reg, mine_reg;        // Read flag, addressed flag
	logic [7:0]  cmd_reg, d0_reg, d1_reg; // Command and data bytes
	logic [7:0]  op_reg;                  // Operation setting
	logic [3:0]  onoff_reg;               // Power-up, cmd, enable, polarity
	logic [2:0]  wl_reg;                  // Lock bits 7..5
	logic [15:0] mlow_reg, mhigh_reg;     // Stored margin targets
	logic [3:0]  nvm_onoff_reg;           // Saved configuration
	logic [2:0]  nvm_wl_reg;              // Saved lock
	logic        boot_reg, pol_eff_reg;   // Boot load done, live polarity
	logic        latch_reg;               // Latched off by a fault
	logic [7:0]  status_reg;              // Sticky status byte
	pom_drive_t  drive_reg;
	logic [15:0] target_reg;
	pom_margin_t margin_reg;

	// Line events seen on the synchronised copies only
	logic scl_s, sda_s, start_ev, stop_ev, rise, fall;
	assign scl_s    = scl_sy[1];
	assign sda_s    = sda_sy[1];
	assign start_ev = scl_s & scl_p & sda_p & ~sda_s;
	assign stop_ev  = scl_s & scl_p & ~sda_p & sda_s;
	assign rise     = scl_s & ~scl_p;
	assign fall     = ~scl_s & scl_p;

	// Synchronisers; first stages feed only the second
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			scl_sy <= 2'h3;
			sda_sy <= 2'h3;
			en_sy  <= 2'h0;
			scl_p  <= 1'b1;
			sda_p  <= 1'b1;
		end else begin
			scl_sy <= {scl_sy[0], i_scl};
			sda_sy <= {sda_sy[0], i_sda};
			en_sy  <= {en_sy[0], i_enable_pin};
			scl_p  <= scl_s;
			sda_p  <= sda_s;
		end
	end

	// Readback; reads never consult the lock
	logic [15:0] rd_word;
	logic [7:0]  rd_byte;
	always_comb begin
		rd_word = 16'h0000;
		unique case (cmd_reg)
			`POM_CMD_OPERATION:   rd_word = {8'h00, op_reg[7], 1'b0, op_reg[5:2], 2'h0};
			`POM_CMD_ONOFF:       rd_word = {8'h00, 3'h0, onoff_reg, `POM_CPA_VALUE};
			`POM_CMD_WLOCK:       rd_word = {8'h00, wl_reg, 5'h00};
			`POM_CMD_MARGIN_HIGH: rd_word = mhigh_reg;
			`POM_CMD_MARGIN_LOW:  rd_word = mlow_reg;
			`POM_CMD_STATUS_BYTE: rd_word = {8'h00, status_reg};
			`POM_CMD_STATUS_WORD: rd_word = {status_reg[`POM_ST_OV] | status_reg[`POM_ST_UV], 7'h00, status_reg};
			default:              rd_word = 16'h0000;
		endcase
		rd_byte = (rcnt_reg == 2'h0) ? rd_word[7:0] : (rcnt_reg == 2'h1) ? rd_word[15:8] : 8'h00;
	end

	// Serial engine: address, command, data bytes, acknowledge, readback
	logic [7:0] rx_byte;
	assign rx_byte = {rx_reg[6:0], sda_s};
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_reg  <= POM_IDLE;
			bit_reg    <= 3'h0;
			rx_reg     <= 8'h00;
			tx_reg     <= 8'h00;
			ack_on_reg <= 1'b0;
			bidx_reg   <= 2'h0;
			wcnt_reg   <= 2'h0;
			rcnt_reg   <= 2'h0;
			rw_reg     <= 1'b0;
			mine_reg   <= 1'b0;
			cmd_reg    <= 8'h00;
			d0_reg     <= 8'h00;
			d1_reg     <= 8'h00;
			o_sda_oe   <= 1'b0;
		end else if (start_ev) begin
			// Start or repeated start; command byte is kept
			state_reg <= POM_RX;
			bit_reg   <= 3'h0;
			bidx_reg  <= 2'h0;
			wcnt_reg  <= 2'h0;
			rcnt_reg  <= 2'h0;
			mine_reg  <= 1'b0;
			o_sda_oe  <= 1'b0;
		end else if (stop_ev) begin
			state_reg <= POM_IDLE;
			mine_reg  <= 1'b0;
			o_sda_oe  <= 1'b0;
		end else begin
			unique case (state_reg)
				POM_IDLE: begin
					o_sda_oe <= 1'b0;
				end
				POM_RX: begin
					if (rise) begin
						rx_reg  <= rx_byte;
						bit_reg <= bit_reg + 3'h1;
						if (bit_reg == 3'h7) begin
							ack_on_reg <= 1'b0;
							if (bidx_reg != 2'h3) begin
								bidx_reg <= bidx_reg + 2'h1;
							end
							if (bidx_reg == 2'h0) begin
								// Address byte: foreign addresses are left alone
								if (rx_byte[7:1] == SLAVE_ADDR) begin
									mine_reg  <= 1'b1;
									rw_reg    <= rx_byte[0];
									state_reg <= POM_ACK;
								end else begin
									state_reg <= POM_IDLE;
								end
							end else begin
								if (bidx_reg == 2'h1) begin
									cmd_reg <= rx_byte;
								end else begin
									if (wcnt_reg == 2'h0) begin
										d0_reg <= rx_byte;
									end
									if (wcnt_reg == 2'h1) begin
										d1_reg <= rx_byte;
									end
									if (wcnt_reg != 2'h3) begin
										wcnt_reg <= wcnt_reg + 2'h1;
									end
								end
								state_reg <= POM_ACK;
							end
						end
					end
				end
				POM_ACK: begin
					// First fall drives acknowledge, second ends it; after a host acknowledge the next fall loads the next byte
					if (fall) begin
						if (!ack_on_reg) begin
							ack_on_reg <= 1'b1;
							o_sda_oe   <= 1'b1;
						end else begin
							ack_on_reg <= 1'b0;
							bit_reg    <= 3'h0;
							if (rw_reg) begin
								tx_reg    <= rd_byte;
								o_sda_oe  <= ~rd_byte[7];
								state_reg <= POM_TX;
								if (rcnt_reg != 2'h3) begin
									rcnt_reg <= rcnt_reg + 2'h1;
								end
							end else begin
								o_sda_oe  <= 1'b0;
								state_reg <= POM_RX;
							end
						end
					end
				end
				POM_TX: begin
					// Data changes on falls, host samples on rises
					if (fall) begin
						o_sda_oe <= ~tx_reg[7];
					end else if (rise) begin
						tx_reg  <= {tx_reg[6:0], 1'b0};
						bit_reg <= bit_reg + 3'h1;
						if (bit_reg == 3'h7) begin
							state_reg <= POM_TACK;
						end
					end
				end
				POM_TACK: begin
					// Host acknowledge asks for the next byte
					if (fall) begin
						o_sda_oe <= 1'b0;
					end else if (rise) begin
						if (!sda_s) begin
							state_reg  <= POM_ACK;
							ack_on_reg <= 1'b1;
						end else begin
							state_reg <= POM_IDLE;
						end
					end
				end
				default: begin
					state_reg <= POM_IDLE;
					o_sda_oe  <= 1'b0;
				end
			endcase
		end
	end
	assign o_sda_o = 1'b0;

	// Write decode at stop: length, lock and data checks
	logic       commit, locked, len_ok, wl_multi, mg_bad, accept, cml_ev, clear_ev;
	logic [1:0] need_len;
	always_comb begin
		commit = stop_ev & mine_reg & ~rw_reg & (bidx_reg >= 2'h2);
		unique case (cmd_reg)
			`POM_CMD_CLEAR, `POM_CMD_STORE_ALL:                            need_len = 2'h0;
			`POM_CMD_OPERATION, `POM_CMD_ONOFF, `POM_CMD_WLOCK, `POM_CMD_STORE_CODE: need_len = 2'h1;
			`POM_CMD_MARGIN_HIGH, `POM_CMD_MARGIN_LOW:                     need_len = 2'h2;
			default:                                                       need_len = 2'h3;
		endcase
		len_ok = (need_len == wcnt_reg) && (need_len != 2'h3);
		if (wl_reg[2]) begin
			locked = (cmd_reg != `POM_CMD_WLOCK);
		end else if (wl_reg[1]) begin
			locked = (cmd_reg != `POM_CMD_WLOCK) && (cmd_reg != `POM_CMD_OPERATION);
		end else if (wl_reg[0]) begin
			locked = (cmd_reg != `POM_CMD_WLOCK) && (cmd_reg != `POM_CMD_OPERATION)
			         && (cmd_reg != `POM_CMD_ONOFF);
		end else begin
			locked = 1'b0;
		end
		wl_multi = (cmd_reg == `POM_CMD_WLOCK) && ((d0_reg[`POM_WL_B7] & d0_reg[`POM_WL_B6])
		           | (d0_reg[`POM_WL_B7] & d0_reg[`POM_WL_B5]) | (d0_reg[`POM_WL_B6] & d0_reg[`POM_WL_B5]));
		mg_bad   = (cmd_reg == `POM_CMD_OPERATION) && (d0_reg[5:4] != 2'h0)
		           && (d0_reg[5:2] != `POM_MG_LOW_IGN) && (d0_reg[5:2] != `POM_MG_LOW_ACT)
		           && (d0_reg[5:2] != `POM_MG_HIGH_IGN) && (d0_reg[5:2] != `POM_MG_HIGH_ACT);
		accept   = commit & len_ok & ~locked & ~wl_multi & ~mg_bad;
		cml_ev   = commit & ~accept;
		clear_ev = accept & (cmd_reg == `POM_CMD_CLEAR);
	end

	// Saved settings; only a factory clear empties them
	always_ff @(posedge i_clk or posedge i_nvm_clr) begin
		if (i_nvm_clr) begin
			nvm_onoff_reg <= `POM_ONOFF_RST;
			nvm_wl_reg    <= `POM_WL_RST;
		end else if (accept && (cmd_reg == `POM_CMD_STORE_ALL)) begin
			nvm_onoff_reg <= onoff_reg;
			nvm_wl_reg    <= wl_reg;
		end else if (accept && (cmd_reg == `POM_CMD_STORE_CODE)) begin
			if (d0_reg == `POM_CMD_ONOFF) begin
				nvm_onoff_reg <= onoff_reg;
			end
			if (d0_reg == `POM_CMD_WLOCK) begin
				nvm_wl_reg <= wl_reg;
			end
		end
	end

	// Live settings; reset stands for a power cycle and reloads the saved copy
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			op_reg      <= `POM_OP_RST;
			onoff_reg   <= `POM_ONOFF_RST;
			wl_reg      <= `POM_WL_RST;
			mlow_reg    <= `POM_MARGIN_RST;
			mhigh_reg   <= `POM_MARGIN_RST;
			boot_reg    <= 1'b0;
			pol_eff_reg <= 1'b1;
		end else if (!boot_reg) begin
			boot_reg    <= 1'b1;
			onoff_reg   <= nvm_onoff_reg;
			wl_reg      <= nvm_wl_reg;
			pol_eff_reg <= nvm_onoff_reg[0];
		end else if (accept) begin
			unique case (cmd_reg)
				`POM_CMD_OPERATION:   op_reg    <= {d0_reg[7], 1'b0, d0_reg[5:2], 2'h0};
				`POM_CMD_ONOFF:       onoff_reg <= d0_reg[4:1];
				`POM_CMD_WLOCK:       wl_reg    <= d0_reg[7:5];
				`POM_CMD_MARGIN_HIGH: mhigh_reg <= {d1_reg, d0_reg};
				`POM_CMD_MARGIN_LOW:  mlow_reg  <= {d1_reg, d0_reg};
				default:              op_reg    <= op_reg;
			endcase
		end
	end

	// Margin decode and start conditions
	logic       mg_low, mg_high, mg_ign, pin_act, start_req;
	pom_fault_t fault_eff;
	always_comb begin
		mg_low    = (op_reg[5:2] == `POM_MG_LOW_IGN) || (op_reg[5:2] == `POM_MG_LOW_ACT);
		mg_high   = (op_reg[5:2] == `POM_MG_HIGH_IGN) || (op_reg[5:2] == `POM_MG_HIGH_ACT);
		mg_ign    = (op_reg[5:2] == `POM_MG_LOW_IGN) || (op_reg[5:2] == `POM_MG_HIGH_IGN);
		fault_eff = i_fault;
		fault_eff.ov = i_fault.ov & ~mg_ign;
		fault_eff.uv = i_fault.uv & ~mg_ign;
		pin_act   = pol_eff_reg ? en_sy[1] : ~en_sy[1];
		start_req = ~onoff_reg[3]
		            | ((~onoff_reg[1] | pin_act)
		               & (~onoff_reg[2] | op_reg[`POM_OP_ON]));
	end

	// Sticky status; a present fault beats a clear in the same cycle
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			status_reg <= 8'h00;
		end else begin
			status_reg <= (clear_ev ? 8'h00 : status_reg)
			              | ({7'h00, fault_eff.ov} << `POM_ST_OV)
			              | ({7'h00, fault_eff.oc} << `POM_ST_OC)
			              | ({7'h00, fault_eff.ot} << `POM_ST_OT)
			              | ({7'h00, fault_eff.uv} << `POM_ST_UV)
			              | ({7'h00, cml_ev} << `POM_ST_CML);
		end
	end

	// Fault latch; released only by removing the start request, not by clear
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			latch_reg <= 1'b0;
		end else if (|fault_eff) begin
			latch_reg <= 1'b1;
		end else if (!start_req) begin
			latch_reg <= 1'b0;
		end
	end

	// Power stage drive and reference; drivers drop within one cycle on off
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			drive_reg  <= '{switch_en: 1'b0, gates_low: 1'b1};
			target_reg <= `POM_VOUT_NOM;
			margin_reg <= POM_MG_OFF;
		end else begin
			drive_reg.switch_en <= boot_reg & start_req & ~latch_reg & ~(|fault_eff);
			drive_reg.gates_low <= ~(boot_reg & start_req & ~latch_reg & ~(|fault_eff));
			// Thresholds track this same value, so margining cannot trip them
			target_reg <= mg_low ? mlow_reg : (mg_high ? mhigh_reg : `POM_VOUT_NOM);
			margin_reg <= mg_low ? POM_MG_LOW : (mg_high ? POM_MG_HIGH : POM_MG_OFF);
		end
	end

	assign o_drive      = drive_reg;
	assign o_ref_target = target_reg;
	assign o_margin     = margin_reg;
	assign o_status     = status_reg;
	assign o_alert_o    = 1'b0;
	assign o_alert_oe   = |status_reg;
endmodule

/* testbench/pom_host.sv */
// Bus host model: bit-level master of the serial link, 160 ns bit time.
// Assumes the data wire has a pull-up and calls start on an i_clk falling edge.
`timescale 1ns/1ps
module pom_host #(
	parameter logic [6:0] ADDR = 7'h2C
) (
	// Link
	input  wire logic i_sda,
	output logic      o_scl,
	output logic      o_sda_oe
);
	// Quarter bit time; multiples of it keep calls on falling edges
	localparam time Q = 40ns;
	// Idle: both lines released, clock stands high
	initial begin
		o_scl = 1'b1;
		o_sda_oe = 1'b0;
	end
	// One bit: data moves mid-low, sampled mid-high
	task automatic bit_x(input logic b, output logic r);
		o_scl = 1'b0;
		#Q o_sda_oe = ~b;
		#Q o_scl = 1'b1;
		#Q r = i_sda;
		#Q;
	endtask
	// Byte then acknowledge bit; a = 1 releases the line
	task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic na);
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], q[i]);
		end
		bit_x(a, na);
	endtask
	// Repeated start first lowers the clock so the slave frees its acknowledge
	task automatic start(input logic rep);
		if (rep) begin
			o_scl = 1'b0;
			#Q o_sda_oe = 1'b0;
			#Q o_scl = 1'b1;
			#Q;
		end
		o_sda_oe = 1'b1;
		#(2*Q);
	endtask
	// Stop, then bus free time for the commit
	task automatic stop();
		o_scl = 1'b0;
		#Q o_sda_oe = 1'b1;
		#Q o_scl = 1'b1;
		#Q o_sda_oe = 1'b0;
		#(8*Q);
	endtask
	// Write n bytes of d, low first; lock data is sent as the caller gives it
	task automatic wr(input logic [7:0] c, input logic [15:0] d, input int n, output logic nak);
		logic [7:0] q;
		logic       a;
		start(1'b0);
		xfer({ADDR, 1'b0}, 1'b1, q, nak);
		xfer(c, 1'b1, q, a);
		nak = nak | a;
		for (int i = 0; i < n; i++) begin
			xfer(d[8*i +: 8], 1'b1, q, a);
			nak = nak | a;
		end
		stop();
	endtask
	// Read one byte, ending with a host NACK
	task automatic rd(input logic [7:0] c, output logic [7:0] q);
		logic [7:0] x;
		logic       a;
		start(1'b0);
		xfer({ADDR, 1'b0}, 1'b1, x, a);
		xfer(c, 1'b1, x, a);
		start(1'b1);
		xfer({ADDR, 1'b1}, 1'b1, x, a);
		xfer(8'hFF, 1'b1, q, a);
		stop();
	endtask
endmodule

/* testbench/pom_top_properties.sv */
// Port checks of the on/off, margin and write-lock block.
// Assumes faults are levels on i_clk and the link idles high.
`timescale 1ns/1ps
`include "pom_defines.svh"
module pom_top_props (
	// Clock and resets
	input wire logic                 i_clk,
	input wire logic                 i_rst,
	input wire logic                 i_nvm_clr,
	// Serial link and alert
	input wire logic                 i_scl,
	input wire logic                 i_sda,
	input wire logic                 o_sda_o,
	input wire logic                 o_sda_oe,
	input wire logic                 o_alert_o,
	input wire logic                 o_alert_oe,
	// Unit side
	input wire logic                 i_enable_pin,
	input wire pom_pkg::pom_fault_t  i_fault,
	input wire pom_pkg::pom_drive_t  o_drive,
	input wire logic [15:0]          o_ref_target,
	input wire pom_pkg::pom_margin_t o_margin,
	input wire logic [7:0]           o_status
);
	import pom_pkg::*;
	// One domain, so clock and reset are given once
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);
	// Fault levels that no margin mode masks
	sequence s_oc; i_fault.oc; endsequence
	sequence s_ot; i_fault.ot; endsequence
	property p_gates; o_drive.gates_low == !o_drive.switch_en; endproperty
	a_gates: assert property (p_gates) else $error("gates not low while stopped");
	property p_oc_stat; s_oc |-> ##[1:2] o_status[`POM_ST_OC]; endproperty
	a_oc_stat: assert property (p_oc_stat) else $error("overcurrent status missing");
	property p_ot_stat; s_ot |-> ##[1:2] o_status[`POM_ST_OT]; endproperty
	a_ot_stat: assert property (p_ot_stat) else $error("temperature status missing");
	property p_oc_stop; s_oc |-> ##[1:3] !o_drive.switch_en; endproperty
	a_oc_stop: assert property (p_oc_stop) else $error("switching on under fault");
	property p_alert; o_alert_oe == (o_status != 8'h00); endproperty
	a_alert: assert property (p_alert) else $error("alert differs from status");
	// Status only falls on a clear, which commits after a stop with the bus clock high
	property p_sticky; $fell(o_status[`POM_ST_OC]) |-> i_scl; endproperty
	a_sticky: assert property (p_sticky) else $error("status fell outside a clear");
	property p_boot; $fell(i_rst) |-> !o_drive.switch_en; endproperty
	a_boot: assert property (p_boot) else $error("switching at reset release");
	property p_nominal; o_margin == POM_MG_OFF |-> o_ref_target == `POM_VOUT_NOM; endproperty
	a_nominal: assert property (p_nominal) else $error("target not nominal");
	// Data line only moves while the bus clock is low
	property p_sda_edge; $changed(o_sda_oe) |-> !i_scl; endproperty
	a_sda_edge: assert property (p_sda_edge) else $error("data moved with clock high");
endmodule
bind pom_top pom_top_props u_pom_top_props (.i_clk, .i_rst, .i_nvm_clr, .i_scl, .i_sda, .o_sda_o,
	.o_sda_oe, .o_alert_o, .o_alert_oe, .i_enable_pin, .i_fault, .o_drive, .o_ref_target, .o_margin, .o_status);

/* testbench/test_pom_top.sv */
// Self-checking bench of the on/off, margin and write-lock block.
// Assumes the host model owns the link; the data wire is pulled up.
`timescale 1ns/1ps
`include "pom_defines.svh"
module test_pom_top;
	import pom_pkg::*;
	// Design pins
	logic        i_clk, i_rst, i_nvm_clr, i_scl, i_enable_pin, h_oe;
	logic        o_sda_o, o_sda_oe, o_alert_o, o_alert_oe;
	pom_fault_t  i_fault;
	pom_drive_t  o_drive;
	logic [15:0] o_ref_target;
	pom_margin_t o_margin;
	logic [7:0]  o_status;
	int          fail_count, n_compared;
	// Open-drain wire: low when either party pulls
	wire         i_sda = ~(h_oe | o_sda_oe);
	pom_top u_pom_top (.i_clk, .i_rst, .i_nvm_clr, .i_scl, .i_sda, .o_sda_o, .o_sda_oe, .o_alert_o,
		.o_alert_oe, .i_enable_pin, .i_fault, .o_drive, .o_ref_target, .o_margin, .o_status);
	pom_host #(.ADDR(`POM_SLAVE_ADDR)) u_pom_host (.i_sda(i_sda), .o_scl(i_scl), .o_sda_oe(h_oe));
	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end
	task automatic final_report();
		$display("Compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("Error t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// Bus write; every byte must be acknowledged, refused or not
	task automatic w(input logic [7:0] c, input logic [15:0] d, input int n);
		logic nak;
		u_pom_host.wr(c, d, n, nak);
		chk(16'(nak), 16'h0000);
	endtask
	task automatic r(input logic [7:0] c, input logic [7:0] e);
		logic [7:0] q;
		u_pom_host.rd(c, q);
		chk(16'(q), 16'(e));
	endtask
	// Bounded wait for the switching enable; a hang ends the run
	task automatic sw(input logic e);
		for (int k = 0; k < 40 && o_drive.switch_en !== e; k++) begin
			@(negedge i_clk);
		end
		chk(16'(o_drive.switch_en), 16'(e));
		chk(16'(o_drive.gates_low), 16'(!e));
		if (o_drive.switch_en !== e) begin
			final_report();
		end
	endtask
	// Level that must hold after the pin synchroniser has settled
	task automatic st(input logic e);
		repeat (20) @(negedge i_clk);
		chk(16'(o_drive.switch_en), 16'(e));
	endtask
	task automatic t_config();
		r(8'h02, 8'h17);
		chk(16'(o_sda_o), 16'h0000);
		r(8'h10, 8'h00);
		i_enable_pin = 1'b1;
		sw(1'b1);
		i_enable_pin = 1'b0;
		sw(1'b0);
		w(8'h02, 16'h00FF, 1);
		r(8'h02, 8'h1F);
		w(8'h01, 16'h0080, 1);
		st(1'b0);
		i_enable_pin = 1'b1;
		sw(1'b1);
		w(8'h01, 16'h0000, 1);
		sw(1'b0);
		w(8'h02, 16'h001A, 1);
		w(8'h01, 16'h0080, 1);
		i_enable_pin = 1'b0;
		st(1'b1);
		w(8'h02, 16'h0000, 1);
		r(8'h02, 8'h01);
		w(8'h01, 16'h0000, 1);
		st(1'b1);
		w(8'h02, 16'h0016, 1);
		sw(1'b0);
	endtask
	task automatic t_margin();
		logic [7:0]  op [5] = '{8'h98, 8'hA8, 8'h94, 8'hA4, 8'h8C};
		pom_margin_t mg [5] = '{POM_MG_LOW, POM_MG_HIGH, POM_MG_LOW, POM_MG_HIGH, POM_MG_OFF};
		logic [15:0] tg [5] = '{16'h1234, 16'h5678, 16'h1234, 16'h5678, 16'h0000};
		w(8'h26, 16'h1234, 2);
		w(8'h25, 16'h5678, 2);
		for (int i = 0; i < 5; i++) begin
			w(8'h01, {8'h00, op[i]}, 1);
			chk(16'(o_margin), 16'(mg[i]));
			chk(o_ref_target, tg[i]);
		end
		w(8'h01, 16'h009C, 1);
		chk(16'(o_margin), 16'(POM_MG_OFF));
		chk(16'(o_status), 16'h0002);
		chk(16'(o_alert_oe), 16'h0001);
		r(8'h78, 8'h02);
		r(8'h79, 8'h02);
		r(8'h25, 8'h78);
		w(8'h03, 16'h0000, 0);
		chk(16'(o_status), 16'h0000);
		chk(16'({o_alert_o, o_alert_oe}), 16'h0000);
		// Ignore-fault margin masks overvoltage; act-on-fault reports it
		w(8'h01, 16'h0094, 1);
		i_fault = 4'h8;
		repeat (4) @(negedge i_clk);
		chk(16'(o_status), 16'h0000);
		w(8'h01, 16'h0098, 1);
		chk(16'(o_status), 16'h0020);
		i_fault = 4'h0;
		w(8'h03, 16'h0000, 0);
		chk(16'(o_status), 16'h0000);
	endtask
	task automatic t_fault();
		i_enable_pin = 1'b1;
		sw(1'b1);
		i_fault = 4'h2;
		sw(1'b0);
		chk(16'(o_status), 16'h0010);
		i_fault = 4'h0;
		w(8'h03, 16'h0000, 0);
		chk(16'(o_status), 16'h0000);
		st(1'b0);
		i_fault = 4'h1;
		w(8'h03, 16'h0000, 0);
		chk(16'(o_status), 16'h0004);
		i_fault = 4'h0;
		w(8'h03, 16'h0000, 0);
		i_enable_pin = 1'b0;
		st(1'b0);
		i_enable_pin = 1'b1;
		sw(1'b1);
	endtask
	task automatic t_lock();
		w(8'h10, 16'h0020, 1);
		w(8'h26, 16'hAAAA, 2);
		r(8'h26, 8'h34);
		chk(16'(o_status), 16'h0002);
		w(8'h02, 16'h001E, 1);
		r(8'h02, 8'h1F);
		w(8'h10, 16'h0040, 1);
		w(8'h02, 16'h0016, 1);
		r(8'h02, 8'h1F);
		w(8'h01, 16'h0098, 1);
		chk(16'(o_margin), 16'(POM_MG_LOW));
		w(8'h10, 16'h0080, 1);
		w(8'h01, 16'h00A8, 1);
		chk(16'(o_margin), 16'(POM_MG_LOW));
		w(8'h10, 16'h0060, 1);
		r(8'h10, 8'h80);
		w(8'h10, 16'h0000, 1);
		w(8'h03, 16'h0000, 0);
		w(8'h10, 16'h00E0, 1);
		chk(16'(o_status), 16'h0002);
		r(8'h10, 8'h00);
		w(8'h02, 16'h0016, 1);
		w(8'h03, 16'h0000, 0);
	endtask
	// Polarity moves only through the saved copy and a power cycle
	task automatic t_pol();
		w(8'h02, 16'h0014, 1);
		r(8'h02, 8'h15);
		st(1'b1);
		w(8'h13, 16'h0002, 1);
		i_rst = 1'b1;
		repeat (3) @(negedge i_clk);
		i_rst = 1'b0;
		repeat (6) @(negedge i_clk);
		r(8'h02, 8'h15);
		st(1'b0);
		i_enable_pin = 1'b0;
		sw(1'b1);
	endtask
	initial begin
		i_rst = 1'b1;
		i_nvm_clr = 1'b1;
		i_enable_pin = 1'b0;
		i_fault = 4'h0;
		fail_count = 0;
		n_compared = 0;
		repeat (2) @(negedge i_clk);
		i_nvm_clr = 1'b0;
		repeat (18) @(negedge i_clk);
		i_rst = 1'b0;
		repeat (6) @(negedge i_clk);
		t_config();
		t_margin();
		t_fault();
		t_lock();
		t_pol();
		final_report();
	end
endmodule
